/* rtl/uio_map.svh */
`ifndef UIO_MAP_SVH
`define UIO_MAP_SVH
// register indices, byte address is four times the index
`define UIO_IDX_CMD      6'h00
`define UIO_IDX_STAT     6'h03
`define UIO_IDX_POL      6'h04
`define UIO_IDX_DIRA     6'h06
`define UIO_IDX_DIRB     6'h07
`define UIO_IDX_PIOLO    6'h08
`define UIO_IDX_PIOHI    6'h09
`define UIO_IDX_MASK     6'h10
// field positions
`define UIO_POL_DRVOFF   5
`define UIO_POL_GATE     4
`define UIO_EN_LSB       4
// reset values
`define UIO_RST_DIR      8'hFF
`define UIO_RST_POL      6'h00
`define UIO_RST_EN       4'h0
`define UIO_RST_BYTE     8'h00
`define UIO_RST_MASK     4'hF
`endif

/* rtl/uio_pkg.sv */
package uio_pkg;
  // gray codes along idle, wait, strobe
  typedef enum logic [1:0]
  {
    PIO_IDLE   = 2'h0,
    PIO_WAIT   = 2'h1,
    PIO_STROBE = 2'h3
  } uio_pio_t;

  typedef struct packed
  {
    logic [1:0]  rstSync;
    logic [3:0]  cmdEn;
    logic [5:0]  pol;
    logic [7:0]  dirA;
    logic [7:0]  dirB;
    logic [7:0]  pioLo;
    logic [7:0]  pioHi;
    logic [3:0]  irqMask;
    logic [3:0]  flags;
    logic [3:0]  statSamp;
    logic [3:0]  statS1;
    logic [3:0]  statS2;
    logic        rxS1;
    logic        rxS2;
    logic        rxPrev;
    logic        txS1;
    logic        txS2;
    logic        txPrev;
    uio_pio_t    pioSt;
    logic [15:0] word;
    logic        strobe;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uio_state_t;
endpackage

/* rtl/uio_status_pio.sv */
`timescale 1ns/1ps
`include "uio_map.svh"
module uio_status_pio
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  userStatus,
  input  wire logic        receiveClock,
  input  wire logic        transmitClock,
  output logic      [15:0] pioWord,
  output logic             outputWordStrobe,
  output logic             driverOffGate,
  output logic      [3:0]  dataDrvEnN,
  output logic      [3:0]  dataRcvEnN,
  output logic      [5:0]  ctrlDrvEnN,
  output logic      [1:0]  ctrlRcvEnN,
  output logic             irq
);

  // ==========================================================
  // reset synchroniser
  logic [1:0] rstPipe;
  logic       rstnInt;

  // async assert, release through two flops
  // two stages keep a late release from meeting the clock edge
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstnInt = rstPipe[1];

  // ==========================================================
  // register decode
  // true for every mapped register index
  function automatic logic regHit(input logic [5:0] idx);
    case (idx)
      `UIO_IDX_CMD, `UIO_IDX_STAT, `UIO_IDX_POL,
      `UIO_IDX_DIRA, `UIO_IDX_DIRB, `UIO_IDX_PIOLO,
      `UIO_IDX_PIOHI, `UIO_IDX_MASK: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  endfunction

  uio_pkg::uio_state_t s;
  uio_pkg::uio_state_t next_s;

  logic [5:0] idx;
  logic       aligned;
  logic       setupPh;
  logic       wrEn;
  logic       rxRise;
  logic       txRise;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] statEvt;
  logic [3:0] w1c;
  logic [7:0] rd;

  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setupPh = psel && !penable;
  // write lands only at the access edge with pready high
  assign wrEn    = psel && penable && s.pready && pwrite
                   && aligned && regHit(idx);

  // ==========================================================
  // link clock edges, found from synchronised copies
  // link clocks are only sampled, never used as clocks; each
  // link half period must span at least two mclk cycles
  assign rxRise = s.rxS2 && !s.rxPrev;
  assign txRise = s.txS2 && !s.txPrev;

  // compare the new sample with the last one
  always_comb
  begin
    rise    = ~s.pol[3:0] & ~s.statSamp & s.statS2;
    fall    = s.pol[3:0] & s.statSamp & ~s.statS2;
    statEvt = rxRise ? ((rise | fall) & s.cmdEn) : 4'h0;
  end

  // ==========================================================
  // read data, formed in the setup cycle
  always_comb
  begin
    rd = 8'h00;
    case (idx)
      `UIO_IDX_CMD:   rd = {s.cmdEn, 4'h0};
      `UIO_IDX_STAT:  rd = {s.flags, s.statSamp};
      `UIO_IDX_POL:   rd = {2'h0, s.pol};
      `UIO_IDX_DIRA:  rd = s.dirA;
      `UIO_IDX_DIRB:  rd = s.dirB;
      `UIO_IDX_PIOLO: rd = s.pioLo;
      `UIO_IDX_PIOHI: rd = s.pioHi;
      `UIO_IDX_MASK:  rd = {s.irqMask, 4'h0};
      default:        rd = 8'h00;
    endcase
  end

  // ==========================================================
  // next state of the whole block
  always_comb
  begin
    next_s = s;
    w1c    = 4'h0;
    // two-flop synchronisers for pins and link clocks
    next_s.statS1 = userStatus;
    next_s.statS2 = s.statS1;
    next_s.rxS1   = receiveClock;
    next_s.rxS2   = s.rxS1;
    next_s.rxPrev = s.rxS2;
    next_s.txS1   = transmitClock;
    next_s.txS2   = s.txS1;
    next_s.txPrev = s.txS2;
    if (rxRise)
      next_s.statSamp = s.statS2;

    // apb: zero wait state, answer prepared in setup cycle
    // no wait states, so the master never sees pready stretch
    next_s.pready  = setupPh;
    if (setupPh)
    begin
      next_s.prdata  = (pwrite || !aligned || !regHit(idx))
                       ? 32'h0 : {24'h0, rd};
      next_s.pslverr = !aligned || !regHit(idx);
    end
    else if (!psel)
    begin
      next_s.pslverr = 1'b0;
    end

    // register writes
    if (wrEn)
    begin
      case (idx)
        `UIO_IDX_CMD:   next_s.cmdEn = pwdata[7:4];
        `UIO_IDX_STAT:  w1c = pwdata[7:4];
        `UIO_IDX_POL:   next_s.pol = pwdata[5:0];
        `UIO_IDX_DIRA:  next_s.dirA = pwdata[7:0];
        `UIO_IDX_DIRB:  next_s.dirB = pwdata[7:0];
        `UIO_IDX_PIOLO: next_s.pioLo = pwdata[7:0];
        `UIO_IDX_PIOHI: next_s.pioHi = pwdata[7:0];
        `UIO_IDX_MASK:  next_s.irqMask = pwdata[7:4];
        default:        next_s.cmdEn = s.cmdEn;
      endcase
    end

    // sticky flags: new event beats a same-cycle clear,
    // and a disabled enable holds its flag clear
    next_s.flags = ((s.flags & ~w1c) | statEvt)
                   & next_s.cmdEn;
    // global gate masks without touching the flags
    next_s.irq = s.pol[`UIO_POL_GATE]
                 && |(s.flags & s.irqMask);

    // programmed word: launched by the high byte write
    // the wait state absorbs the phase gap to the next transmit edge
    case (s.pioSt)
      uio_pkg::PIO_IDLE:
      begin
        next_s.strobe = 1'b0;
        if (wrEn && idx == `UIO_IDX_PIOHI)
          next_s.pioSt = uio_pkg::PIO_WAIT;
      end
      uio_pkg::PIO_WAIT:
      begin
        if (txRise)
        begin
          next_s.word   = {s.pioHi, s.pioLo};
          next_s.strobe = 1'b1;
          next_s.pioSt  = uio_pkg::PIO_STROBE;
        end
      end
      uio_pkg::PIO_STROBE:
      begin
        // a high write now only updates the byte
        if (txRise)
        begin
          next_s.strobe = 1'b0;
          next_s.pioSt  = uio_pkg::PIO_IDLE;
        end
      end
      default:
      begin
        next_s.strobe = 1'b0;
        next_s.pioSt  = uio_pkg::PIO_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  // field reset values come from the map header
  always_ff @(posedge mclk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      s          <= '0;
      s.cmdEn    <= `UIO_RST_EN;
      s.pol      <= `UIO_RST_POL;
      s.dirA     <= `UIO_RST_DIR;
      s.dirB     <= `UIO_RST_DIR;
      s.pioLo    <= `UIO_RST_BYTE;
      s.pioHi    <= `UIO_RST_BYTE;
      s.irqMask  <= `UIO_RST_MASK;
      s.pioSt    <= uio_pkg::PIO_IDLE;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // outputs straight from the state flops
  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign pioWord          = s.word;
  assign outputWordStrobe = s.strobe;
  assign driverOffGate    = s.pol[`UIO_POL_DRVOFF];
  // enables are independent, so both may be on at once
  assign dataDrvEnN       = s.dirA[7:4];
  assign dataRcvEnN       = s.dirA[3:0];
  assign ctrlDrvEnN       = s.dirB[7:2];
  assign ctrlRcvEnN       = s.dirB[1:0];
  assign irq              = s.irq;

  // ==========================================================
  // assertions
  // internal state, outputs and the apb inputs, never the raw link pins
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstnInt);

  a_apb_ready_once: assert property (
    setupPh |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");

  a_unmapped_err: assert property (
    (setupPh && !regHit(idx)) |=> pslverr)
    else $error("unmapped access without error");

  a_gate_masks_irq: assert property (
    !s.pol[`UIO_POL_GATE] |=> !irq)
    else $error("irq while global gate closed");

  a_gate_keeps_flags: assert property (
    ($fell(s.pol[`UIO_POL_GATE]) && $past(statEvt) == 4'h0 && $past(w1c) == 4'h0
     && $stable(s.cmdEn)) |-> $stable(s.flags))
    else $error("gate changed the flags");

  a_rise_sets_flag: assert property (
    (rxRise && !s.pol[0] && !s.statSamp[0] && s.statS2[0]
     && s.cmdEn[0] && next_s.cmdEn[0]) |=> s.flags[0])
    else $error("rising status did not set flag");

  a_fall_sets_flag: assert property (
    (rxRise && s.pol[1] && s.statSamp[1] && !s.statS2[1]
     && s.cmdEn[1] && next_s.cmdEn[1]) |=> s.flags[1])
    else $error("falling status did not set flag");

  a_flag_needs_en: assert property (
    !s.cmdEn[2] |-> !s.flags[2])
    else $error("flag set with enable clear");

  a_strobe_on_tx: assert property (
    $rose(outputWordStrobe) |-> $past(txRise)
    ##1 (outputWordStrobe throughout (!txRise) [*2]))
    else $error("strobe not held until next tx edge");

  a_strobe_len: assert property (
    (outputWordStrobe && txRise) |=> !outputWordStrobe)
    else $error("strobe longer than one tx cycle");

  a_word_bytes: assert property (
    $rose(outputWordStrobe) |-> pioWord == {s.pioHi, s.pioLo})
    else $error("word bytes misplaced");

  a_drvoff_gate: assert property (
    (wrEn && idx == `UIO_IDX_POL) |=>
    driverOffGate == $past(pwdata[5]))
    else $error("driver-off gate not from bit 5");

  // bus answer shape: one ready per setup, error drops with psel
  a_ready_from_setup: assert property (
    pready |-> $past(setupPh))
    else $error("pready without a setup cycle");

  a_err_released: assert property (
    !psel |=> !pslverr)
    else $error("pslverr held after psel low");

  a_read_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");

  // register fields reach their pins one cycle after the write; unused polarity bits read back zero
  a_pol_read_zero: assert property (
    (setupPh && !pwrite && idx == `UIO_IDX_POL)
    |=> prdata[7:6] == 2'h0)
    else $error("unused polarity bits read back set");

  a_dir_a_map: assert property (
    (wrEn && idx == `UIO_IDX_DIRA)
    |=> {dataDrvEnN, dataRcvEnN} == $past(pwdata[7:0]))
    else $error("direction A not on its enables");

  a_dir_b_map: assert property (
    (wrEn && idx == `UIO_IDX_DIRB)
    |=> {ctrlDrvEnN, ctrlRcvEnN} == $past(pwdata[7:0]))
    else $error("direction B not on its enables");

  // status capture and flag bookkeeping
  a_stat_sample: assert property (
    rxRise |=> s.statSamp == $past(s.statS2))
    else $error("status not captured on receive edge");

  a_no_stray_flag: assert property (
    (!s.flags[3] && !statEvt[3]) |=> !s.flags[3])
    else $error("flag set without a status event");

  a_enable_clears: assert property (
    (wrEn && idx == `UIO_IDX_CMD && !pwdata[4]) |=> !s.flags[0])
    else $error("clearing the enable kept the flag");

  a_w1c_clears: assert property (
    (wrEn && idx == `UIO_IDX_STAT && pwdata[4] && !statEvt[0])
    |=> !s.flags[0])
    else $error("write one did not clear the flag");

  a_irq_follows: assert property (
    (s.pol[`UIO_POL_GATE] && (s.flags & s.irqMask) != 4'h0)
    |=> irq)
    else $error("irq low with an open unmasked flag");

  // the word only moves when a new strobe starts
  a_word_stable: assert property (
    !$rose(outputWordStrobe) |-> $stable(pioWord))
    else $error("word changed outside a launch");

  c_pio_word: cover property ($rose(outputWordStrobe));
  c_irq_high: cover property ($rose(irq));
  c_flag_clear: cover property ($fell(s.flags[0]));
  c_slverr: cover property (pslverr && pready);
  c_fall_flag: cover property (rxRise && (fall & s.cmdEn) != 4'h0);

endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  statDrive = 4'h0;
  logic [31:0] prdata, rd, rnd;
  logic        pready, pslverr, er, outputWordStrobe, driverOffGate, irq;
  logic        receiveClock, transmitClock;
  logic [3:0]  userStatus, dataDrvEnN, dataRcvEnN, m;
  logic [15:0] pioWord, gotWord, w;
  logic [5:0]  ctrlDrvEnN;
  logic [1:0]  ctrlRcvEnN;
  int          num_errors = 0;
  int          n_checks = 0;
  int          gotCount, n0, t;

  uio_status_pio u_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .userStatus, .receiveClock, .transmitClock, .pioWord, .outputWordStrobe,
    .driverOffGate, .dataDrvEnN, .dataRcvEnN, .ctrlDrvEnN, .ctrlRcvEnN, .irq);
  uio_user_dev u_dev (.statDrive, .pioWord, .outputWordStrobe, .userStatus, .receiveClock,
    .transmitClock, .gotWord, .gotCount);

  always #2.5 mclk = ~mclk;

  // ====
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected status register: flags above, sampled pins below
  function automatic logic [31:0] statExp(input logic [3:0] f, input logic [3:0] p);
    return {24'h0, f, p};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic waitIrq();
    t = 0;
    while (irq !== 1'b1 && t < 100)
    begin
      @(posedge mclk);
      t++;
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ====
  // watchdog, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  // ====
  // main sequence
  initial
  begin
    rnd = 32'h2345;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk(8'h18, 32'hFF);
    rdchk(8'h1C, 32'hFF);
    rdchk(8'h40, 32'hF0);
    chk({ctrlDrvEnN, ctrlRcvEnN, dataDrvEnN, dataRcvEnN}, 32'hFFFF);
    apb(1'b0, 8'h14, 32'h0);
    chk(er, 1'b1);
    // all-on corner, the usual write setup, then random
    for (int i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hCC0F : rnd[15:0];
      apb(1'b1, 8'h18, {24'h0, w[7:0]});
      apb(1'b1, 8'h1C, {24'h0, w[15:8]});
      chk({ctrlDrvEnN, ctrlRcvEnN, dataDrvEnN, dataRcvEnN}, w);
    end
    apb(1'b1, 8'h10, 32'hFF);
    rdchk(8'h10, 32'h3F);
    chk(driverOffGate, 1'b1);
    apb(1'b1, 8'h10, 32'h0F);
    repeat (2) @(posedge mclk);
    chk(driverOffGate, 1'b0);
    // programmed words, strobe length in mclk cycles
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      n0 = gotCount;
      apb(1'b1, 8'h20, {24'h0, rnd[7:0]});
      apb(1'b1, 8'h24, {24'h0, rnd[15:8]});
      t = 0;
      while (outputWordStrobe !== 1'b1 && t < 100)
      begin
        @(posedge mclk);
        t++;
      end
      chk(outputWordStrobe, 1'b1);
      chk(pioWord, rnd[15:0]);
      t = 0;
      while (outputWordStrobe === 1'b1 && t < 100)
      begin
        @(posedge mclk);
        t++;
      end
      chk(t, 16);
      repeat (20) @(posedge mclk);
      chk(gotWord, rnd[15:0]);
      chk(gotCount - n0, 1);
    end
    // status edges for both polarities
    apb(1'b1, 8'h00, 32'hF0);
    for (int p = 0; p < 2; p++)
    begin
      statDrive <= p ? 4'hF : 4'h0;
      apb(1'b1, 8'h10, p ? 32'h1F : 32'h10);
      repeat (64) @(posedge mclk);
      apb(1'b1, 8'h0C, 32'hF0);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      rnd = lfsr(rnd);
      // bits 0 and 1 always move, so both edge kinds are exercised
      m = rnd[3:0] | 4'h3;
      statDrive <= statDrive ^ m;
      waitIrq();
      chk(irq, 1'b1);
      rdchk(8'h0C, statExp(m, statDrive));
      apb(1'b1, 8'h10, p ? 32'h0F : 32'h00);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      rdchk(8'h0C, statExp(m, statDrive));
      apb(1'b1, 8'h40, 32'h00);
      apb(1'b1, 8'h10, p ? 32'h1F : 32'h10);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      apb(1'b1, 8'h40, 32'hF0);
      waitIrq();
      chk(irq, 1'b1);
      apb(1'b1, 8'h00, 32'h00);
      apb(1'b1, 8'h00, 32'hF0);
      statDrive <= statDrive ^ m;
      repeat (64) @(posedge mclk);
      rdchk(8'h0C, statExp(4'h0, statDrive));
      chk(irq, 1'b0);
    end
    summarize();
  end
endmodule

/* verif/uio_user_dev.sv */
`timescale 1ns/1ps
// ====
// user device on the connector
module uio_user_dev
(
  input  wire logic [3:0]  statDrive,
  input  wire logic [15:0] pioWord,
  input  wire logic        outputWordStrobe,
  output logic      [3:0]  userStatus,
  output logic             receiveClock,
  output logic             transmitClock,
  output logic      [15:0] gotWord,
  output int               gotCount
);
  // link clocks run free at one period, tx offset by a fixed 17 ns from rx
  initial
  begin
    receiveClock = 1'b0;
    transmitClock = 1'b0;
    userStatus = 4'h0;
    gotWord = 16'h0000;
    gotCount = 0;
    #17;
    forever #40 transmitClock = ~transmitClock;
  end
  always #40 receiveClock = ~receiveClock;

  // status moves half a period before the sampling edge
  always @(negedge receiveClock)
    userStatus <= statDrive;

  // latch a word per strobed transmit cycle
  always @(posedge transmitClock)
    if (outputWordStrobe === 1'b1)
    begin
      gotWord <= pioWord;
      gotCount <= gotCount + 1;
    end
endmodule
